// ---- hdl/tpc_pkg.sv ----
/*
 * Shared constants and carrier types of the tuner synthesizer control block.
 * Assumes a 10 MHz system clock and an Avalon-MM register master.
 */
package tpc_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0]  REG_DIVIDER   = 4'h0;
    localparam logic [3:0]  REG_CONTROL   = 4'h4;
    localparam logic [3:0]  REG_STATUS    = 4'h8;

    // ==========================================================
    // reset values
    localparam logic [14:0] DIVIDER_RST   = 15'h0100;
    localparam logic [7:0]  CTRL1_RST     = 8'h8E;
    localparam logic [7:0]  CTRL2_RST     = 8'h00;

    // ==========================================================
    // control byte one fields
    localparam int          C1_PAIR_BIT   = 7;
    localparam int          C1_PUMP_HIGH  = 6;
    localparam int          C1_ROUTE      = 5;
    localparam int          C1_TRISTATE   = 4;
    localparam int          C1_TUNE_OFF   = 0;
    // control byte two fields
    localparam int          C2_BAND_UHF   = 7;

    // ==========================================================
    // bus address: upper five bits fixed, low two from the select pin
    localparam logic [4:0]  BUS_ADDR_HI   = 5'h18;

    // ==========================================================
    // timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          PULSE_MAX_NS  = 250;
    localparam int          PULSE_MAX_CYC = (PULSE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int          REF_DIV       = 64;
    localparam int          LOCK_PERIODS  = 8;
    localparam logic [14:0] DIV_MIN       = 15'h0100;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } tpc_avreq_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } tpc_avrsp_s;

    typedef struct packed {
        logic src;
        logic snk;
        logic high;
    } tpc_pump_s;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK, I2C_WAIT
    } tpc_i2c_e;

endpackage

// ---- hdl/tpc_top.sv ----
/*
 * Digital control section of the tuner synthesizer: two-wire slave, reference
 * and programmable dividers, phase detector steering, lock detector, power-on
 * flag, test routing and switch ports, plus an Avalon-MM register slave.
 * Assumes all pin inputs are synchronous to CLK_I, XTAL_TICK_I pulses once per
 * crystal period and VCO_I is a prescaled oscillator level.
 */
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps

module tpc_top
    import tpc_pkg::*;
(
    // clock and reset
    input  wire logic               CLK_I,
    input  wire logic               RST_B_I,
    // register bus
    input  wire tpc_pkg::tpc_avreq_s AVS_REQ_I,
    output tpc_pkg::tpc_avrsp_s     AVS_RSP_O,
    // two-wire bus
    input  wire logic               SCL_I,
    input  wire logic               SDA_I,
    output logic                    SDA_O,
    output logic                    SDA_OE_O,
    input  wire logic [1:0]         ADDR_SEL_I,
    // synthesizer
    input  wire logic               XTAL_TICK_I,
    input  wire logic               VCO_I,
    input  wire logic               SUPPLY_LOW_I,
    output tpc_pkg::tpc_pump_s      PUMP_O,
    output logic                    TUNE_EN_O,
    output logic                    UHF_EN_O,
    output logic                    VHF_EN_O,
    // switch ports and converter
    input  wire logic [2:0]         PORT_I,
    output logic [2:0]              PORT_O,
    output logic [2:0]              PORT_OE_O,
    input  wire logic [2:0]         ADC_I
);
    import tpc_pkg::*;

    typedef struct packed {
        tpc_i2c_e    state;
        logic [3:0]  bcnt;
        logic [7:0]  sh;
        logic        rw;
        logic        second;
        logic [7:0]  first;
        logic        rdtel;
        logic        scl_q;
        logic        sda_q;
        logic        drv;
        logic [14:0] divider;
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic        por;
        logic        lock;
        logic [3:0]  lcnt;
        logic        bad;
        logic [3:0]  pw;
        logic [5:0]  xcnt;
        logic        vco_q;
        logic [14:0] vcnt;
        logic        ref_q;
        logic        dv_q;
        logic        up;
        logic        dn;
        logic        av_ack;
        logic [31:0] av_rdata;
    } tpc_state_s;

    tpc_state_s  st_q;
    tpc_state_s  st_d;

    logic        t0;
    logic        t1;
    logic [14:0] ratio;
    logic        dv;
    logic        ref_sig;
    logic        dv_sig;
    logic [7:0]  status;
    logic        av_acc;
    logic [2:0]  route;

    // ==========================================================
    // derived signals
    assign t0      = st_q.ctrl1[C1_TRISTATE];
    assign t1      = st_q.ctrl1[C1_ROUTE];
    // ratios below the legal floor are clamped so the divider never degenerates
    assign ratio   = (st_q.divider < DIV_MIN) ? DIV_MIN : st_q.divider;
    assign dv      = st_q.vcnt < {1'b0, ratio[14:1]};
    // both test bits hand the phase detector to the port inputs
    assign ref_sig = (t1 && t0) ? PORT_I[0] : st_q.xcnt[5];
    assign dv_sig  = (t1 && t0) ? PORT_I[1] : dv;
    assign status  = {st_q.por, st_q.lock, 1'b0, PORT_I[1], PORT_I[0], ADC_I};
    assign av_acc  = AVS_REQ_I.read || AVS_REQ_I.write;
    assign route   = {1'b0, dv, st_q.xcnt[4]};

    // ==========================================================
    // next state
    always_comb begin
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic ref_fall;
        logic dv_fall;
        start    = 1'b0;
        stop     = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        ref_fall = 1'b0;
        dv_fall  = 1'b0;
        st_d     = st_q;

        // register bus: one wait state, then the access completes
        st_d.av_ack = av_acc && !st_q.av_ack;
        if (av_acc && !st_q.av_ack) begin
            if (AVS_REQ_I.address == REG_DIVIDER) begin
                st_d.av_rdata = {17'h00000, st_q.divider};
            end else if (AVS_REQ_I.address == REG_CONTROL) begin
                st_d.av_rdata = {16'h0000, st_q.ctrl2, st_q.ctrl1};
            end else if (AVS_REQ_I.address == REG_STATUS) begin
                st_d.av_rdata = {24'h000000, status};
            end else begin
                st_d.av_rdata = 32'h00000000;
            end
        end
        if (AVS_REQ_I.write && st_q.av_ack) begin
            if (AVS_REQ_I.address == REG_DIVIDER) begin
                if (AVS_REQ_I.byteenable[0]) st_d.divider[7:0] = AVS_REQ_I.writedata[7:0];
                if (AVS_REQ_I.byteenable[1]) st_d.divider[14:8] = AVS_REQ_I.writedata[14:8];
            end else if (AVS_REQ_I.address == REG_CONTROL) begin
                if (AVS_REQ_I.byteenable[0]) st_d.ctrl1 = AVS_REQ_I.writedata[7:0];
                if (AVS_REQ_I.byteenable[1]) st_d.ctrl2 = AVS_REQ_I.writedata[15:8];
            end
        end

        // two-wire slave
        st_d.scl_q = SCL_I;
        st_d.sda_q = SDA_I;
        start = st_q.scl_q && SCL_I && st_q.sda_q && !SDA_I;
        stop  = st_q.scl_q && SCL_I && !st_q.sda_q && SDA_I;
        rise  = !st_q.scl_q && SCL_I;
        fall  = st_q.scl_q && !SCL_I;
        if (start) begin
            st_d.state  = I2C_ADDR;
            st_d.bcnt   = 4'h0;
            st_d.drv    = 1'b0;
            st_d.second = 1'b0;
            st_d.rdtel  = 1'b0;
        end else if (stop) begin
            // an unpaired first byte is dropped at the stop
            if (st_q.rdtel) st_d.por = 1'b0;
            st_d.state  = I2C_IDLE;
            st_d.drv    = 1'b0;
            st_d.rdtel  = 1'b0;
            st_d.second = 1'b0;
        end else begin
            case (st_q.state)
                I2C_ADDR, I2C_WR: begin
                    if (rise) begin
                        st_d.sh   = {st_q.sh[6:0], SDA_I};
                        st_d.bcnt = st_q.bcnt + 4'h1;
                    end else if (fall && st_q.bcnt == 4'h8) begin
                        if (st_q.state == I2C_ADDR) begin
                            if (st_q.sh[7:1] == {BUS_ADDR_HI, ADDR_SEL_I}) begin
                                st_d.drv   = 1'b1;
                                st_d.rw    = st_q.sh[0];
                                st_d.state = I2C_AACK;
                            end else begin
                                st_d.state = I2C_WAIT;
                            end
                        end else begin
                            st_d.drv   = 1'b1;
                            st_d.state = I2C_WACK;
                            if (!st_q.second) begin
                                st_d.first  = st_q.sh;
                                st_d.second = 1'b1;
                            end else begin
                                st_d.second = 1'b0;
                                if (st_q.first[C1_PAIR_BIT]) begin
                                    st_d.ctrl1 = st_q.first;
                                    st_d.ctrl2 = st_q.sh;
                                end else begin
                                    st_d.divider = {st_q.first[6:0], st_q.sh};
                                end
                            end
                        end
                    end
                end
                I2C_AACK: begin
                    if (fall) begin
                        st_d.bcnt = 4'h0;
                        if (st_q.rw) begin
                            st_d.rdtel = 1'b1;
                            st_d.sh    = status;
                            st_d.drv   = !status[7];
                            st_d.state = I2C_RD;
                        end else begin
                            st_d.drv   = 1'b0;
                            st_d.state = I2C_WR;
                        end
                    end
                end
                I2C_WACK: begin
                    if (fall) begin
                        st_d.drv   = 1'b0;
                        st_d.bcnt  = 4'h0;
                        st_d.state = I2C_WR;
                    end
                end
                I2C_RD: begin
                    if (fall) begin
                        if (st_q.bcnt == 4'h7) begin
                            st_d.drv   = 1'b0;
                            st_d.state = I2C_RACK;
                        end else begin
                            st_d.sh   = {st_q.sh[6:0], 1'b0};
                            st_d.drv  = !st_q.sh[6];
                            st_d.bcnt = st_q.bcnt + 4'h1;
                        end
                    end
                end
                I2C_RACK: begin
                    // no acknowledge: stay off the line until the stop
                    if (rise && SDA_I) begin
                        st_d.state = I2C_WAIT;
                    end else if (fall) begin
                        st_d.sh    = status;
                        st_d.drv   = !status[7];
                        st_d.bcnt  = 4'h0;
                        st_d.state = I2C_RD;
                    end
                end
                default: begin
                    st_d.drv = 1'b0;
                end
            endcase
        end
        // set wins over the clearing read
        if (SUPPLY_LOW_I) st_d.por = 1'b1;

        // reference divider
        if (XTAL_TICK_I) st_d.xcnt = st_q.xcnt + 6'h01;

        // programmable divider
        st_d.vco_q = VCO_I;
        if (VCO_I && !st_q.vco_q) begin
            st_d.vcnt = (st_q.vcnt >= 15'(ratio - 15'h0001)) ? 15'h0000 : st_q.vcnt + 15'h0001;
        end

        // phase detector on falling edges
        st_d.ref_q = ref_sig;
        st_d.dv_q  = dv_sig;
        ref_fall   = st_q.ref_q && !ref_sig;
        dv_fall    = st_q.dv_q && !dv_sig;
        st_d.up    = st_q.up || dv_fall;
        st_d.dn    = st_q.dn || ref_fall;
        if (st_d.up && st_d.dn) begin
            st_d.up = 1'b0;
            st_d.dn = 1'b0;
        end

        // lock detector
        st_d.pw = (st_q.up || st_q.dn) ? ((st_q.pw == 4'hF) ? st_q.pw : st_q.pw + 4'h1) : 4'h0;
        if (ref_fall) begin
            st_d.bad = 1'b0;
            if (st_q.bad) begin
                st_d.lcnt = 4'h0;
            end else if (st_q.lcnt == 4'(LOCK_PERIODS - 1)) begin
                st_d.lock = 1'b1;
            end else begin
                st_d.lcnt = st_q.lcnt + 4'h1;
            end
        end
        if (st_d.pw > 4'(PULSE_MAX_CYC)) begin
            st_d.lock = 1'b0;
            st_d.bad  = 1'b1;
            st_d.lcnt = 4'h0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q         <= '0;
            st_q.state   <= I2C_IDLE;
            st_q.scl_q   <= 1'b1;
            st_q.sda_q   <= 1'b1;
            st_q.divider <= DIVIDER_RST;
            st_q.ctrl1   <= CTRL1_RST;
            st_q.ctrl2   <= CTRL2_RST;
            st_q.por     <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    assign AVS_RSP_O.readdata    = st_q.av_rdata;
    assign AVS_RSP_O.waitrequest = av_acc && !st_q.av_ack;
    assign SDA_O       = 1'b0;
    assign SDA_OE_O    = st_q.drv;
    assign PUMP_O.src  = st_q.up && !t0;
    assign PUMP_O.snk  = st_q.dn && !t0;
    assign PUMP_O.high = st_q.ctrl1[C1_PUMP_HIGH];
    assign TUNE_EN_O   = !st_q.ctrl1[C1_TUNE_OFF];
    assign UHF_EN_O    = st_q.ctrl2[C2_BAND_UHF];
    assign VHF_EN_O    = !st_q.ctrl2[C2_BAND_UHF];

    // open collector: enable pulls the pin low; a routed test signal sinks while low
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_port
            assign PORT_O[gi]    = 1'b0;
            assign PORT_OE_O[gi] = (t1 && gi < 2) ? !route[gi] : st_q.ctrl2[gi];
        end
    endgenerate

    // ==========================================================
    // checks
    ref_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (!(t1 && t0) && $fell(st_q.xcnt[5])) |-> st_q.xcnt == 6'h00)
        else $error("reference edge off the 64 count");
    ratio_floor_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        st_q.vcnt < ratio || $changed(st_q.divider) || $past(st_q.divider) != st_q.divider)
        else $error("divider count passed the ratio");
    pump_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        !(PUMP_O.src && PUMP_O.snk))
        else $error("source and sink together");
    pump_tri_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        st_q.ctrl1[C1_TRISTATE] |-> !PUMP_O.src && !PUMP_O.snk)
        else $error("pump active in tristate test");
    sda_drive_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        SDA_OE_O |-> st_q.state inside {I2C_AACK, I2C_WACK, I2C_RD})
        else $error("data pulled low outside ack or read");
    ack_slot_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (st_q.state == I2C_WR && $past(st_q.state) == I2C_WACK) |-> $past(SDA_OE_O))
        else $error("write byte left unacknowledged");
    lock_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (st_q.pw > 4'(PULSE_MAX_CYC)) |-> !st_q.lock)
        else $error("lock held through a long pulse");
    lock_set_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        $rose(st_q.lock) |-> $past(st_q.lcnt) == 4'(LOCK_PERIODS - 1))
        else $error("lock set early");
    por_set_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        SUPPLY_LOW_I |=> st_q.por)
        else $error("supply drop missed");
    port_on_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (!t1 && st_q.ctrl2[0]) |-> PORT_OE_O[0])
        else $error("port zero not active");

    write_pair_c: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
        st_q.second ##[1:1000] !st_q.second && st_q.state == I2C_WACK);
    read_done_c: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
        $fell(st_q.por) && !SUPPLY_LOW_I);
    lock_rise_c: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
        $rose(st_q.lock));

endmodule

// ---- tb/tpc_i2c_mst.sv ----
/*
 * Bus master model of the controlling processor for the two-wire link.
 * Assumes an open-drain data wire with pull-up resolved by the bench,
 * and a clock that is 10 MHz so 4 cycles per phase meet the >=2 cycle need.
 */
`timescale 1ns/10ps

// ==========================================================
// master model
module tpc_i2c_mst (
    // clock
    input  wire logic clk_i,
    // bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    // clock stands high between telegrams
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic hp();
        repeat (4) @(posedge clk_i);
    endtask

    task automatic start();
        sda_pull_o <= 1'b0;
        scl_o      <= 1'b1;
        hp();
        sda_pull_o <= 1'b1;
        hp();
        scl_o      <= 1'b0;
        hp();
    endtask

    // data changes only while the clock is low
    task automatic xfer(input logic b, output logic r);
        sda_pull_o <= ~b;
        hp();
        scl_o <= 1'b1;
        hp();
        r = sda_i;
        scl_o <= 1'b0;
        hp();
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, d[i]);
        end
        xfer(~more, r);
    endtask

    task automatic stop();
        sda_pull_o <= 1'b1;
        hp();
        scl_o <= 1'b1;
        hp();
        sda_pull_o <= 1'b0;
        hp();
    endtask
endmodule

// ---- tb/tb_tuner_pll_i2c_control.sv ----
/*
 * Self-checking bench of the synthesizer control block.
 * Assumes tpc_pkg and tpc_top compiled first; register reads are scored
 * from a queue by a monitor, pin results by direct compares.
 */
`timescale 1ns/10ps

module tb_tuner_pll_i2c_control;
    import tpc_pkg::*;

    // ==========================================================
    // signals
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    tpc_avreq_s  req = '0;
    tpc_avrsp_s  rsp;
    tpc_pump_s   pump;
    logic        scl, pull, sda_oe, tune, uhf, vhf, xtal = 1'b0, vco = 1'b0, sup_low = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [2:0]  port_in = 3'h7, adc = 3'h0, port_oe;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0]  d;
    logic        ack;
    integer      seed = 32'h67518C2A, error_cnt = 0, n_checks = 0, cyc = 0, xph = 0, n;

    always #50 clk = ~clk;

    tpc_top dut (.CLK_I(clk), .RST_B_I(rst_b), .AVS_REQ_I(req), .AVS_RSP_O(rsp),
        .SCL_I(scl), .SDA_I(~(pull | sda_oe)), .SDA_O(), .SDA_OE_O(sda_oe), .ADDR_SEL_I(sel),
        .XTAL_TICK_I(xtal), .VCO_I(vco), .SUPPLY_LOW_I(sup_low), .PUMP_O(pump),
        .TUNE_EN_O(tune), .UHF_EN_O(uhf), .VHF_EN_O(vhf), .PORT_I(port_in & ~port_oe),
        .PORT_O(), .PORT_OE_O(port_oe), .ADC_I(adc));

    tpc_i2c_mst mst (.clk_i(clk), .sda_i(~(pull | sda_oe)), .scl_o(scl), .sda_pull_o(pull));

    // ==========================================================
    // crystal at 4 MHz: two ticks every five cycles; free-running oscillator
    always @(posedge clk) begin
        xph  <= (xph == 4) ? 0 : xph + 1;
        xtal <= (xph == 0) || (xph == 2);
        vco  <= 1'($random(seed));
        cyc  <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    // ==========================================================
    // compares and report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rd(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
        chk("readdata", e, g & m);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // read data are taken at the rising edge where waitrequest is sampled low
    always @(posedge clk) begin
        if (req.read && rsp.waitrequest === 1'b0 && exp_q.size() > 0)
            chk_rd(exp_q.pop_front(), msk_q.pop_front(), rsp.readdata);
    end

    // ==========================================================
    // register bus master
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        req <= '{read: ~w, write: w, address: a, byteenable: 4'hF, writedata: wd};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        req <= '0;
    endtask

    task automatic av_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        av(1'b0, a, 32'h0);
    endtask

    // two-byte write telegram; ack of the address and first data byte compared with expectation
    task automatic i2c_wr(input logic [1:0] s, input logic [7:0] b1, input logic [7:0] b2, input logic ea);
        mst.start();
        mst.wr_byte({BUS_ADDR_HI, s, 1'b0}, ack);
        chk("addr ack", ea, ack);
        mst.wr_byte(b1, ack);
        chk("data ack", ea, ack);
        mst.wr_byte(b2, ack);
        mst.stop();
    endtask

    function automatic logic [31:0] st(input logic por);
        return {24'h0, por, 2'b00, port_in[1:0], adc};
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        port_in <= 3'($random(seed));
        adc     <= 3'($random(seed));
        sel     <= 2'($random(seed));
        repeat (5) @(posedge clk);
        chk("reset pins", {1'b0, 1'b1, 1'b0, 1'b1, 3'h0}, {sda_oe, tune, uhf, vhf, port_oe});
        rst_b <= 1'b1;
        av_rd(REG_STATUS, st(1'b1), 32'h9F);
        av_rd(REG_CONTROL, {24'h0, CTRL1_RST}, 32'hFFFF);
        av_rd(REG_DIVIDER, {17'h0, DIVIDER_RST}, 32'h7FFF);
        av_rd(4'hC, 32'h0, 32'hFFFFFFFF);
        av(1'b1, REG_CONTROL, 32'h0000_00CF);
        repeat (3) @(posedge clk);
        chk("pump high", 2'b10, {pump.high, tune});
        i2c_wr(sel, 8'h9E, 8'h84, 1'b1);
        repeat (3) @(posedge clk);
        chk("ctrl pins", 6'b011010, {pump.high, tune, uhf, vhf, port_oe[2:1]});
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (pump.src !== 1'b0 || pump.snk !== 1'b0)
                chk("pump idle", 2'b00, {pump.src, pump.snk});
        end
        i2c_wr(sel, 8'h7F, 8'hFF, 1'b1);
        mst.start();
        mst.wr_byte({BUS_ADDR_HI, sel, 1'b0}, ack);
        mst.wr_byte(8'hFF, ack);
        mst.stop();
        i2c_wr(sel ^ 2'h1, 8'h80, 8'h00, 1'b0);
        av_rd(REG_CONTROL, 32'h849E, 32'hFFFF);
        av_rd(REG_DIVIDER, 32'h7FFF, 32'h7FFF);
        mst.start();
        mst.wr_byte({BUS_ADDR_HI, sel, 1'b1}, ack);
        chk("read ack", 1'b1, ack);
        mst.rd_byte(1'b1, d);
        chk("status", st(1'b1), {24'h0, d & 8'h9F});
        mst.rd_byte(1'b0, d);
        chk("status2", st(1'b1), {24'h0, d & 8'h9F});
        mst.stop();
        @(negedge clk);
        chk("released", 1'b0, sda_oe);
        av_rd(REG_STATUS, 32'h0, 32'h80);
        sup_low <= 1'b1;
        repeat (3) @(posedge clk);
        sup_low <= 1'b0;
        av_rd(REG_STATUS, 32'h80, 32'h80);
        av(1'b1, REG_CONTROL, 32'h0000_84AE);
        do @(negedge clk); while (port_oe[0] !== 1'b0);
        do @(negedge clk); while (port_oe[0] !== 1'b1);
        // one full period: down again, then up again
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (port_oe[0] !== 1'b0 && n < 200);
        do begin
            @(negedge clk);
            n = n + 1;
        end while (port_oe[0] !== 1'b1 && n < 200);
        chk("route period", 32'd80, n);
        final_report();
    end
endmodule
